//--- core/clk_path_pkg.sv
// Constants for the clock path and input selection control bank.
// Assumes one register clock; the serial host port decodes transfers
// into byte-wide register writes and reads before they reach this bank.
package clk_path_pkg;

    // Register offsets
    localparam logic [7:0] clock_path_control_addr = 8'h00;
    localparam logic [7:0] input_priority_addr = 8'h01;
    localparam logic [7:0] loop_bandwidth_select_addr = 8'h02;
    localparam logic [7:0] input_select_hold_control_addr = 8'h03;

    // Field positions in clock_path_control
    localparam int free_run_bit = 6;
    localparam int output_force_on_bit = 5;
    localparam int bypass_bit = 1;

    // Field positions in input_priority
    localparam int second_priority_lsb = 2;
    localparam int first_priority_lsb = 0;

    // Field position in loop_bandwidth_select
    localparam int loop_bandwidth_lsb = 4;

    // Field positions in input_select_hold_control
    localparam int register_choice_lsb = 6;
    localparam int hold_force_bit = 5;
    localparam int calib_squelch_bit = 4;

    // Reset values
    localparam logic [7:0] clock_path_control_rst = 8'h00;
    localparam logic [7:0] input_priority_rst = 8'he4;
    localparam logic [7:0] loop_bandwidth_select_rst = 8'h00;
    localparam logic [7:0] input_select_hold_control_rst = 8'h00;

    // Reserved upper nibble of input_priority reads as its reset pattern
    localparam logic [3:0] priority_reserved_rd = 4'he;

    // Input codes shared by priority and register choice fields
    localparam logic [1:0] choice_input_one = 2'h0;
    localparam logic [1:0] choice_input_two = 2'h1;

    // Selection method codes
    localparam logic [1:0] method_manual = 2'h0;
    localparam logic [1:0] method_auto_nonrevert = 2'h1;
    localparam logic [1:0] method_auto_revert = 2'h2;

    // Unmapped reads return this
    localparam logic [7:0] unmapped_rd = 8'h00;

endpackage

//--- core/sync_two_ff.sv
// Two-stage synchroniser for one asynchronous level.
// Assumes the input is a slow level such as a board pin.
`timescale 1ns/1ps
module sync_two_ff (
    input wire logic sys_clk, // Register clock
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic async_in, // Level from outside the domain
    output logic sync_out // Level safe to use on sys_clk
);
    logic stage_one;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage_one <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule // sync_two_ff

//--- core/clock_path_select_control.sv
// Control bank for clock path routing, squelch, bypass and input choice.
// Assumes register writes and reads arrive decoded on sys_clk; the
// calibration engine, input quality monitors and the method and format
// registers live elsewhere on the same clock. The choice pin is async.
`timescale 1ns/1ps
module clock_path_select_control
    import clk_path_pkg::*;
(
    input wire logic sys_clk, // Register clock, 250 MHz
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic reg_wr_en, // One-cycle register write strobe
    input wire logic reg_rd_en, // One-cycle register read strobe
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data, valid cycle after read
    input wire logic [1:0] selection_method, // Method code from bank
    input wire logic pin_choice_enable, // Pin controls manual choice
    input wire logic input_choice_pin, // External choice pin, async
    input wire logic ref_one_valid, // Input one quality good
    input wire logic ref_two_valid, // Input two quality good
    input wire logic calib_busy, // Internal calibration running
    input wire logic calib_pass, // Last calibration succeeded
    input wire logic output_format_cmos, // An output set to CMOS
    output logic crystal_to_input_two, // Crystal feeds input two path
    output logic clock_output_enable, // Output buffers not squelched
    output logic pll_bypass, // Selected input drives outputs
    output logic bypass_format_conflict, // Bypass asked with CMOS
    output logic active_input, // 0 input one, 1 input two
    output logic hold_active, // Digital hold in force
    output logic [3:0] applied_bandwidth, // Bandwidth code in use
    output logic calibrated // A calibration has completed well
);

    // Stored register fields
    logic free_run;
    logic output_force_on;
    logic bypass_req;
    logic [1:0] second_priority_field;
    logic [1:0] first_priority_field;
    logic [3:0] loop_bandwidth_code;
    logic [1:0] register_input_choice;
    logic hold_force;
    logic calib_output_squelch;

    // Internal state
    logic calib_busy_q;
    logic pin_sync;

    // Pin enters through two flops before any decision looks at it
    sync_two_ff u_pin_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in(input_choice_pin),
        .sync_out(pin_sync)
    );

    // Address decode
    wire wr_ctrl = reg_wr_en && (reg_addr == clock_path_control_addr);
    wire wr_prio = reg_wr_en && (reg_addr == input_priority_addr);
    wire wr_bw = reg_wr_en && (reg_addr == loop_bandwidth_select_addr);
    wire wr_sel = reg_wr_en
        && (reg_addr == input_select_hold_control_addr);

    // Register writes; only defined fields are stored
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            free_run <= clock_path_control_rst[free_run_bit];
            output_force_on <= clock_path_control_rst[output_force_on_bit];
            bypass_req <= clock_path_control_rst[bypass_bit];
        end else if (wr_ctrl) begin
            free_run <= reg_wdata[free_run_bit];
            output_force_on <= reg_wdata[output_force_on_bit];
            bypass_req <= reg_wdata[bypass_bit];
        end
    end

    // Priority fields reset so input one leads and input two follows
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            second_priority_field <=
                input_priority_rst[second_priority_lsb +: 2];
            first_priority_field <=
                input_priority_rst[first_priority_lsb +: 2];
        end else if (wr_prio) begin
            second_priority_field <= reg_wdata[second_priority_lsb +: 2];
            first_priority_field <= reg_wdata[first_priority_lsb +: 2];
        end
    end

    // Bandwidth code is only staged here until calibration ends
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            loop_bandwidth_code <=
                loop_bandwidth_select_rst[loop_bandwidth_lsb +: 4];
        end else if (wr_bw) begin
            loop_bandwidth_code <= reg_wdata[loop_bandwidth_lsb +: 4];
        end
    end

    // Selection and hold control fields
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            register_input_choice <=
                input_select_hold_control_rst[register_choice_lsb +: 2];
            hold_force <= input_select_hold_control_rst[hold_force_bit];
            calib_output_squelch <=
                input_select_hold_control_rst[calib_squelch_bit];
        end else if (wr_sel) begin
            register_input_choice <= reg_wdata[register_choice_lsb +: 2];
            hold_force <= reg_wdata[hold_force_bit];
            calib_output_squelch <= reg_wdata[calib_squelch_bit];
        end
    end

    // Read mux; reserved bits read zero, except the priority nibble
    logic [7:0] rd_ctrl;
    logic [7:0] rd_prio;
    logic [7:0] rd_bw;
    logic [7:0] rd_sel;
    logic [7:0] next_rdata;
    assign rd_ctrl = {1'b0, free_run, output_force_on, 3'h0,
        bypass_req, 1'b0};
    assign rd_prio = {priority_reserved_rd, second_priority_field,
        first_priority_field};
    assign rd_bw = {loop_bandwidth_code, 4'h0};
    assign rd_sel = {register_input_choice, hold_force,
        calib_output_squelch, 4'h0};
    assign next_rdata =
        (reg_addr == clock_path_control_addr) ? rd_ctrl :
        (reg_addr == input_priority_addr) ? rd_prio :
        (reg_addr == loop_bandwidth_select_addr) ? rd_bw :
        (reg_addr == input_select_hold_control_addr) ? rd_sel :
        unmapped_rd;

    // Read data holds until the next read strobe
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= unmapped_rd;
        end else if (reg_rd_en) begin
            reg_rdata <= next_rdata;
        end
    end

    // Calibration end is the falling edge of busy
    wire calib_end = calib_busy_q && !calib_busy;

    // Track calibration; bandwidth code is applied only at its end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            calib_busy_q <= 1'b0;
            calibrated <= 1'b0;
            applied_bandwidth <=
                loop_bandwidth_select_rst[loop_bandwidth_lsb +: 4];
        end else begin
            calib_busy_q <= calib_busy;
            if (calib_end) begin
                calibrated <= calib_pass;
                applied_bandwidth <= loop_bandwidth_code;
            end
        end
    end

    // Squelch: only when the squelch bit is on and the part is in or
    // before a good calibration; force-on beats squelch outright
    wire squelch_now = calib_output_squelch
        && (calib_busy || !calibrated);
    wire next_output_enable = output_force_on || !squelch_now;

    // Priority decoding; reserved codes name no usable input
    wire first_ok = (first_priority_field == choice_input_one)
        ? ref_one_valid
        : (first_priority_field == choice_input_two)
        ? ref_two_valid : 1'b0;
    wire second_ok = (second_priority_field == choice_input_one)
        ? ref_one_valid
        : (second_priority_field == choice_input_two)
        ? ref_two_valid : 1'b0;
    wire first_input = (first_priority_field == choice_input_two);
    wire second_input = (second_priority_field == choice_input_two);
    wire current_ok = active_input ? ref_two_valid : ref_one_valid;

    // Manual choice: pin when enabled, else register field
    wire reg_choice_legal = (register_input_choice == choice_input_one)
        || (register_input_choice == choice_input_two);
    wire reg_choice_input =
        (register_input_choice == choice_input_two);
    wire manual_input = pin_choice_enable ? pin_sync
        : (reg_choice_legal ? reg_choice_input : active_input);

    // Automatic choice for both flavours
    logic auto_input;
    logic auto_hold;
    always_comb begin
        auto_input = active_input;
        auto_hold = 1'b0;
        if (selection_method == method_auto_nonrevert && current_ok) begin
            auto_input = active_input;
        end else if (first_ok) begin
            auto_input = first_input;
        end else if (second_ok) begin
            auto_input = second_input;
        end else begin
            auto_hold = 1'b1;
        end
    end

    // Method decode; reserved method keeps the present input
    wire is_manual = (selection_method == method_manual);
    wire is_auto = (selection_method == method_auto_nonrevert)
        || (selection_method == method_auto_revert);
    wire next_input = hold_force ? active_input
        : is_manual ? manual_input
        : is_auto ? auto_input : active_input;
    wire next_hold = hold_force || (is_auto && auto_hold);

    // Bypass is refused while a CMOS format is set, since the buffer
    // cannot pass a raw input in that format
    wire next_conflict = bypass_req && output_format_cmos;
    wire next_bypass = bypass_req && !output_format_cmos;

    // Output flops
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            crystal_to_input_two <= 1'b0;
            clock_output_enable <= 1'b0;
            pll_bypass <= 1'b0;
            bypass_format_conflict <= 1'b0;
            active_input <= 1'b0;
            hold_active <= 1'b0;
        end else begin
            crystal_to_input_two <= free_run;
            clock_output_enable <= next_output_enable;
            pll_bypass <= next_bypass;
            bypass_format_conflict <= next_conflict;
            active_input <= next_input;
            hold_active <= next_hold;
        end
    end

endmodule // clock_path_select_control

//--- verification/clock_path_select_control_sva.sv
// Checker: shadow of the bank and port relations of the clock path block.
// Assumes one sys_clk domain; bound to the top module by name.
`timescale 1ns/1ps
module clock_path_select_control_sva
    import clk_path_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic reg_wr_en, // Write strobe
    input wire logic reg_rd_en, // Read strobe
    input wire logic [7:0] reg_addr, // Offset
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic [1:0] selection_method, // Method code
    input wire logic pin_choice_enable, // Pin mode
    input wire logic input_choice_pin, // Choice pin
    input wire logic calib_busy, // Calibration running
    input wire logic output_format_cmos, // CMOS format
    input wire logic crystal_to_input_two, // Free-run route
    input wire logic clock_output_enable, // Outputs driven
    input wire logic pll_bypass, // Bypass in force
    input wire logic bypass_format_conflict, // Bypass refused
    input wire logic active_input, // Chosen input
    input wire logic hold_active, // Digital hold
    input wire logic [3:0] applied_bandwidth, // Code in use
    input wire logic calibrated // Calibration done
);
    logic [7:0] s0, s2, s3;
    logic [3:0] s1;
    logic [2:0] idle, run;
    // Shadow bank, written on the same edge as the design's registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s0 <= 8'h00;
            s1 <= 4'h4;
            s2 <= 8'h00;
            s3 <= 8'h00;
        end else if (reg_wr_en) begin
            case (reg_addr)
                8'h00: s0 <= reg_wdata;
                8'h01: s1 <= reg_wdata[3:0];
                8'h02: s2 <= reg_wdata;
                8'h03: s3 <= reg_wdata;
                default: ;
            endcase
        end
    end
    // Saturating counts: edges since reset, samples with calibration idle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            run <= 3'h0;
            idle <= 3'h0;
        end else begin
            run <= (run == 3'h7) ? run : run + 3'h1;
            idle <= calib_busy ? 3'h0 : ((idle == 3'h7) ? idle : idle + 3'h1);
        end
    end
    // Expected values; the design shows them one edge later
    wire exp_en = s0[5] | !(s3[4] & (calib_busy | !calibrated));
    wire [7:0] rd_exp = (reg_addr == 8'h00) ? (s0 & 8'h62) :
        (reg_addr == 8'h01) ? {4'he, s1} :
        (reg_addr == 8'h02) ? (s2 & 8'hf0) :
        (reg_addr == 8'h03) ? (s3 & 8'hf0) : 8'h00;
    wire manual = (selection_method == 2'h0) && !s3[5];
    wire reg_mode = manual && !pin_choice_enable && !s3[7];
    wire pin_mode = manual && pin_choice_enable;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // Reset clears s3, so three hold samples imply no reset in between
    sequence hold_kept;
        s3[5] [*3];
    endsequence

    free_run_a: assert property (run != 3'h0 |->
        crystal_to_input_two == $past(s0[6])) else $error("free run wrong");
    out_enable_a: assert property (run != 3'h0 |->
        clock_output_enable == $past(exp_en)) else $error("squelch wrong");
    bypass_route_a: assert property (run != 3'h0 |->
        pll_bypass == $past(s0[1] & !output_format_cmos))
        else $error("bypass wrong");
    bypass_cmos_a: assert property (run != 3'h0 |->
        bypass_format_conflict == $past(s0[1] & output_format_cmos))
        else $error("cmos conflict wrong");
    read_back_a: assert property ($past(reg_rd_en) && run != 3'h0 |->
        reg_rdata == $past(rd_exp)) else $error("read data wrong");
    hold_freeze_a: assert property (hold_kept |->
        hold_active && $stable(active_input)) else $error("hold wrong");
    reg_choice_a: assert property ($past(reg_mode) && run != 3'h0 |->
        active_input == $past(s3[6])) else $error("register choice wrong");
    pin_choice_a: assert property (run > 3'h3 && $past(pin_mode) &&
        $past(input_choice_pin, 2) == $past(input_choice_pin, 3) |->
        active_input == $past(input_choice_pin, 3)) else $error("pin wrong");
    bw_hold_a: assert property (idle == 3'h7 |->
        $stable(applied_bandwidth) && $stable(calibrated))
        else $error("bandwidth moved without calibration");
endmodule // clock_path_select_control_sva

//--- verification/clock_path_select_control_test.sv
// Testbench: register tasks and scenarios for the clock path bank.
// Assumes the package, the bank and its checker are compiled first.
`timescale 1ns/1ps
module clock_path_select_control_test;
    import clk_path_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [1:0] selection_method = 2'h0;
    logic pin_choice_enable = 1'b0;
    logic input_choice_pin = 1'b0;
    logic ref_one_valid = 1'b1;
    logic ref_two_valid = 1'b1;
    logic calib_busy = 1'b0;
    logic calib_pass = 1'b0;
    logic output_format_cmos = 1'b0;
    logic [7:0] reg_rdata;
    logic crystal_to_input_two, clock_output_enable, pll_bypass, calibrated;
    logic bypass_format_conflict, active_input, hold_active;
    logic [3:0] applied_bandwidth;
    int n_fail = 0;
    int compares = 0;
    // Auto steps: method, input one valid, input two valid, active, hold
    logic [5:0] step [10] = '{6'h2e, 6'h28, 6'h21, 6'h26, 6'h2e, 6'h28,
        6'h2e, 6'h18, 6'h1c, 6'h30};
    wire [7:0] outs = {2'h0, crystal_to_input_two, clock_output_enable,
        pll_bypass, bypass_format_conflict, active_input, hold_active};

    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    clock_path_select_control DUT (
        .sys_clk, .sys_rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
        .reg_rdata, .selection_method, .pin_choice_enable, .input_choice_pin,
        .ref_one_valid, .ref_two_valid, .calib_busy, .calib_pass,
        .output_format_cmos, .crystal_to_input_two, .clock_output_enable,
        .pll_bypass, .bypass_format_conflict, .active_input, .hold_active,
        .applied_bandwidth, .calibrated
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic pause(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Strobes rise and fall on falling edges, so one rising edge takes them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
        chk(reg_rdata, exp);
    endtask
    task automatic stop_test;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog cuts a hung run short
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        stop_test();
    end

    initial begin
        pause(12);
        sys_rst = 1'b0;
        rd(8'h00, 8'h00);
        rd(8'h01, 8'he4);
        rd(8'h03, 8'h00);
        chk(outs, 8'h10);
        $display("test reset_values done");
        // All ones: reserved bits must stay put, hold freezes input one
        for (int a = 0; a < 6; a++) wr(8'(a), 8'hff);
        rd(8'h00, 8'h62);
        rd(8'h01, 8'hef);
        rd(8'h02, 8'hf0);
        rd(8'h03, 8'hf0);
        rd(8'h05, 8'h00);
        chk(outs, 8'h39);
        chk({4'h0, applied_bandwidth}, 8'h00);
        output_format_cmos = 1'b1;
        pause(3);
        chk(outs, 8'h35);
        output_format_cmos = 1'b0;
        $display("test all_ones done");
        wr(8'h02, 8'ha0);
        wr(8'h00, 8'h00);
        wr(8'h03, 8'h10);
        pause(3);
        chk({7'h0, clock_output_enable}, 8'h00);
        calib_pass = 1'b1;
        calib_busy = 1'b1;
        pause(4);
        calib_busy = 1'b0;
        pause(4);
        chk({3'h0, calibrated, applied_bandwidth}, 8'h1a);
        for (int i = 0; i < 8; i++) begin
            wr(8'h00, {2'h0, i[2], 5'h0});
            wr(8'h03, {3'h0, i[1], 4'h0});
            calib_busy = i[0];
            pause(3);
            chk(8'(clock_output_enable), 8'(i[2] | !(i[1] & i[0])));
            calib_busy = 1'b0;
        end
        $display("test calibration done");
        wr(8'h03, 8'h40);
        pause(3);
        chk({7'h0, active_input}, 8'h01);
        wr(8'h03, 8'h80);
        pause(3);
        chk({7'h0, active_input}, 8'h01);
        wr(8'h03, 8'h00);
        pin_choice_enable = 1'b1;
        input_choice_pin = 1'b1;
        pause(6);
        chk({7'h0, active_input}, 8'h01);
        input_choice_pin = 1'b0;
        wr(8'h03, 8'h40);
        pause(6);
        chk({7'h0, active_input}, 8'h00);
        pin_choice_enable = 1'b0;
        wr(8'h01, 8'h01);
        for (int i = 0; i < 10; i++) begin
            selection_method = step[i][5:4];
            ref_one_valid = step[i][3];
            ref_two_valid = step[i][2];
            pause(3);
            chk(8'({active_input, hold_active}), 8'(step[i][1:0]));
        end
        $display("test selection done");
        selection_method = 2'h2;
        ref_one_valid = 1'b1;
        ref_two_valid = 1'b1;
        wr(8'h03, 8'h20);
        pause(4);
        chk({6'h0, active_input, hold_active}, 8'h03);
        // Input two goes bad under hold; the choice must not move
        ref_two_valid = 1'b0;
        pause(3);
        chk({6'h0, active_input, hold_active}, 8'h03);
        ref_two_valid = 1'b1;
        wr(8'h03, 8'h00);
        pause(3);
        chk({6'h0, active_input, hold_active}, 8'h02);
        $display("test hold_force done");
        stop_test();
    end
endmodule // clock_path_select_control_test

bind clock_path_select_control clock_path_select_control_sva chk_inst (.*);
